// ===== fcoa_regs.svh
`ifndef FCOA_REGS_SVH
`define FCOA_REGS_SVH

// byte offsets within the privileged register page
`define FCOA_OFS_LOS_THR      8'h09
`define FCOA_OFS_SUPP_TMR     8'h0a
`define FCOA_OFS_FAULT_MASK   8'h0b
`define FCOA_OFS_PW_SET0      8'h0c
`define FCOA_OFS_PW_SET3      8'h0f
// entered password bytes at the user page
`define FCOA_OFS_PW_ENT0      8'h7b
`define FCOA_OFS_PW_ENT3      8'h7e

// fault mask field positions
`define FCOA_BIT_PRIV_IRQ_MASK 7
`define FCOA_BIT_HOUR_EN       6
`define FCOA_BIT_SAT_MASK      3
`define FCOA_BIT_TX_MASK       2
`define FCOA_BIT_BIAS_MASK     1
`define FCOA_BIT_DIODE_MASK    0
`define FCOA_MASK_WR_BITS      8'hcf

// reset values
`define FCOA_RST_BYTE          8'h00
`define FCOA_RST_PW            32'h00000000

// suppression tick timing
`define FCOA_CLK_PERIOD_NS     10
`define FCOA_TICK_NS           500000
`define FCOA_TICK_CYCLES       (`FCOA_TICK_NS / `FCOA_CLK_PERIOD_NS)

`endif

// ===== fcoa_pkg.sv
package fcoa_pkg;

    // suppression timer states, one-hot
    typedef enum logic [2:0] {
        FCOA_ST_IDLE = 3'b001,
        FCOA_ST_HOLD = 3'b010,
        FCOA_ST_RUN  = 3'b100
    } fcoa_supp_e;

    typedef logic [7:0] fcoa_byte_t;

endpackage

// ===== fcoa_fault_chan.sv
`timescale 1ns/1ps

// one fault channel: sticky record plus masked output
module fcoa_fault_chan
(
    input  wire logic clock_i,      // system clock
    input  wire logic reset_i,      // sync reset
    input  wire logic detect_i,     // raw fault condition this cycle
    input  wire logic clear_i,      // software clear of the flag
    input  wire logic mask_i,       // one masks the fault
    output logic      flag_o,       // recorded fault, unmasked
    output logic      fault_o       // flag gated by mask
);
    logic flag_q;                   // sticky record
    logic flag_d;                   // next value

    // set beats clear so a fault arriving on the clear is kept
    assign flag_d  = detect_i | (flag_q & ~clear_i);
    // masked fault stays recorded but not reported
    assign fault_o = flag_q & ~mask_i;
    assign flag_o  = flag_q;

    // flag register
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end
endmodule

// ===== fcoa_supp_timer.sv
`timescale 1ns/1ps
`include "fcoa_regs.svh"

// saturation-fault suppression window after laser turn-on
module fcoa_supp_timer
    import fcoa_pkg::*;
(
    input  wire logic       clock_i,    // system clock
    input  wire logic       reset_i,    // sync reset
    input  wire logic       laser_on_i, // laser enable level
    input  wire fcoa_byte_t interval_i, // count of half-ms ticks
    output logic            suppress_o  // high while window runs
);
    localparam int TICK_CYC = `FCOA_TICK_CYCLES;
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

    fcoa_supp_e  state_q;       // timer state
    fcoa_supp_e  state_d;       // next state
    fcoa_byte_t  count_q;       // ticks left
    fcoa_byte_t  count_d;       // next ticks left
    logic [15:0] pre_q;         // tick prescaler
    logic [15:0] pre_d;         // next prescaler
    logic        laser_q;       // last laser level
    logic        turn_on;       // rising edge of laser enable
    logic        tick;          // half-millisecond tick

    assign turn_on    = laser_on_i & ~laser_q;
    assign tick       = (pre_q == TICK_LAST);
    // covers the turn-on cycle too
    assign suppress_o = (state_q == FCOA_ST_RUN) | (turn_on & (interval_i != 8'h00));

    // next-state logic; zero interval skips the window entirely
    always_comb
    begin
        state_d = state_q;
        count_d = count_q;
        pre_d   = tick ? 16'h0000 : pre_q + 16'h0001;
        case (state_q)
            FCOA_ST_IDLE:
            begin
                if (turn_on && interval_i != 8'h00)
                begin
                    state_d = FCOA_ST_RUN;
                    count_d = interval_i;
                    pre_d   = 16'h0000;
                end
            end
            FCOA_ST_RUN:
            begin
                if (!laser_on_i)
                    state_d = FCOA_ST_IDLE;         // laser dropped, abandon
                else if (tick)
                begin
                    count_d = count_q - 8'h01;
                    if (count_q == 8'h01)
                        state_d = FCOA_ST_HOLD;
                end
            end
            FCOA_ST_HOLD:
            begin
                // window over, wait for laser off before rearming
                if (!laser_on_i)
                    state_d = FCOA_ST_IDLE;
            end
            default:
                state_d = FCOA_ST_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            state_q <= FCOA_ST_IDLE;
            count_q <= 8'h00;
            pre_q   <= 16'h0000;
            laser_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            count_q <= count_d;
            pre_q   <= pre_d;
            laser_q <= laser_on_i;
        end
    end
endmodule

// ===== fcoa_fault_config.sv
`timescale 1ns/1ps
`include "fcoa_regs.svh"

module fcoa_fault_config
    import fcoa_pkg::*;
(
    input  wire logic       clock_i,           // system clock
    input  wire logic       reset_i,           // sync reset (power-on or warm)
    // register port from the serial bus engine
    input  wire logic       wr_en_i,           // one-cycle write strobe
    input  wire logic       rd_en_i,           // one-cycle read strobe
    input  wire logic       priv_page_i,       // access targets privileged page
    input  wire fcoa_byte_t addr_i,            // byte address
    input  wire fcoa_byte_t wdata_i,           // write data
    output fcoa_byte_t      rdata_o,           // read data, registered
    output logic            rvalid_o,          // read data valid pulse

    // non-volatile backing store image
    input  wire fcoa_byte_t nv_los_thr_i,      // stored threshold
    input  wire fcoa_byte_t nv_supp_tmr_i,     // stored timer
    input  wire fcoa_byte_t nv_fault_mask_i,   // stored mask
    input  wire logic [31:0] nv_pw_set_i,      // stored password setting
    output logic            nv_wr_o,           // store update pulse
    output fcoa_byte_t      nv_addr_o,         // store byte address
    output fcoa_byte_t      nv_wdata_o,        // store byte data

    // fault comparator inputs
    input  wire logic       fault_comparator_disable_i, // stop comparator
    input  wire fcoa_byte_t rx_power_i,        // measured received power
    input  wire logic       laser_on_i,        // laser enable level
    input  wire logic       sat_detect_i,      // power loop saturated
    input  wire logic       tx_high_i,         // tx power over threshold
    input  wire logic       bias_high_i,       // bias over threshold
    input  wire logic       diode_fault_i,     // diode fault seen
    input  wire logic       global_interrupt_enable_i, // user enable
    input  wire logic       irq_src_i,         // pending interrupt source
    input  wire logic [4:0] flag_clr_i,        // clear: los,sat,tx,bias,diode

    // outputs
    output logic [4:0]      flags_o,           // recorded flags, unmasked
    output logic            fault_o,           // any unmasked fault
    output logic            int_n_o,           // interrupt, active low
    output logic            hour_meter_enable_o, // hour meter run
    output logic            priv_unlocked_o    // privileged pages open
);
    // copies of store
    fcoa_byte_t  los_thr_q;         // loss threshold
    fcoa_byte_t  supp_tmr_q;        // suppression interval
    fcoa_byte_t  mask_q;            // fault mask control
    logic [31:0] pw_set_q;          // password setting, as stored
    logic [31:0] pw_live_q;         // password in effect
    logic [31:0] pw_ent_q;          // entered password field
    logic        loaded_q;          // store image taken after reset

    // bus flops
    fcoa_byte_t  rdata_q;           // read data register
    logic        rvalid_q;          // read valid register
    logic        nv_wr_q;           // store strobe register
    fcoa_byte_t  nv_addr_q;         // store address register
    fcoa_byte_t  nv_wdata_q;        // store data register

    // status flops
    logic        fault_q;           // fault output register
    logic        int_n_q;           // interrupt output register
    logic        hour_q;            // hour meter output register
    logic        unl_q;             // unlock output register

    // channel nets
    logic [4:0]  flag_w;            // channel flags
    logic [4:0]  fout_w;            // channel masked faults
    logic [4:0]  det_w;             // channel detects
    logic [4:0]  msk_w;             // channel masks
    logic        suppress;          // saturation window active
    logic        run;               // comparator running

    // access
    logic        unlocked;          // password matches
    logic        priv_ok;           // privileged access permitted
    logic        wr_priv;           // permitted privileged write
    logic        rd_priv;           // permitted privileged read
    logic        wr_ent;            // entered-password write

    // decode and read path
    logic        sel_thr;           // address decodes
    logic        sel_tmr;
    logic        sel_msk;
    logic        sel_pw;
    logic        sel_ent;
    logic [1:0]  pw_lane;           // password byte lane
    fcoa_byte_t  pw_byte;           // selected password byte
    fcoa_byte_t  rd_mux;            // read mux

    // password match against the setting in effect, not the fresh write
    assign unlocked = (pw_ent_q == pw_live_q);
    // needs the image
    assign priv_ok  = priv_page_i & unlocked & loaded_q;
    assign wr_priv  = wr_en_i & priv_ok;
    assign rd_priv  = rd_en_i & priv_ok;
    // user page, open to all
    assign wr_ent   = wr_en_i & ~priv_page_i & sel_ent;

    // address decode
    assign sel_thr = (addr_i == `FCOA_OFS_LOS_THR);
    assign sel_tmr = (addr_i == `FCOA_OFS_SUPP_TMR);
    assign sel_msk = (addr_i == `FCOA_OFS_FAULT_MASK);
    // four setting bytes
    assign sel_pw  = (addr_i >= `FCOA_OFS_PW_SET0) && (addr_i <= `FCOA_OFS_PW_SET3);
    assign sel_ent = (addr_i >= `FCOA_OFS_PW_ENT0) && (addr_i <= `FCOA_OFS_PW_ENT3);
    // lane shared by both fields
    // byte 0 is least significant at the lowest address
    assign pw_lane = sel_pw ? addr_i[1:0] : 2'(addr_i - `FCOA_OFS_PW_ENT0);
    assign pw_byte = pw_set_q[pw_lane*8 +: 8];

    // read mux; reserved mask bits read as zero
    assign rd_mux = sel_thr ? los_thr_q :
                    sel_tmr ? supp_tmr_q :
                    sel_msk ? (mask_q & `FCOA_MASK_WR_BITS) :
                    sel_pw  ? pw_byte : `FCOA_RST_BYTE;

    // comparator runs only when not disabled; old flags hold
    // los, tx, bias only
    assign run = ~fault_comparator_disable_i;

    assign det_w[4] = run & (rx_power_i < los_thr_q);
    assign det_w[3] = sat_detect_i & ~suppress;
    assign det_w[2] = run & tx_high_i;
    assign det_w[1] = run & bias_high_i;
    assign det_w[0] = diode_fault_i;

    // masks
    assign msk_w[4] = 1'b0;                                       // loss has no mask bit
    assign msk_w[3] = mask_q[`FCOA_BIT_SAT_MASK];
    assign msk_w[2] = mask_q[`FCOA_BIT_TX_MASK];
    assign msk_w[1] = mask_q[`FCOA_BIT_BIAS_MASK];
    assign msk_w[0] = mask_q[`FCOA_BIT_DIODE_MASK];

    // one channel per fault source
    // five alike, set beats clear
    genvar g;

    generate
        for (g = 0; g < 5; g++)
        begin : g_chan
            fcoa_fault_chan u_chan
            (
                .clock_i  (clock_i),
                .reset_i  (reset_i),
                .detect_i (det_w[g]),
                .clear_i  (flag_clr_i[g]),
                .mask_i   (msk_w[g]),
                .flag_o   (flag_w[g]),
                .fault_o  (fout_w[g])
            );
        end
    endgenerate

    // saturation suppression timer
    // rearms on each turn-on
    fcoa_supp_timer u_supp
    (
        .clock_i    (clock_i),
        .reset_i    (reset_i),
        .laser_on_i (laser_on_i),
        .interval_i (supp_tmr_q),
        .suppress_o (suppress)
    );

    // configuration registers; reload from store after every reset
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            // held until reload
            los_thr_q  <= `FCOA_RST_BYTE;
            supp_tmr_q <= `FCOA_RST_BYTE;
            mask_q     <= `FCOA_RST_BYTE;
            pw_set_q   <= `FCOA_RST_PW;
            loaded_q   <= 1'b0;
        end
        else if (!loaded_q)
        begin
            // reset cannot sample ports, so image is taken just after
            los_thr_q  <= nv_los_thr_i;
            supp_tmr_q <= nv_supp_tmr_i;
            mask_q     <= nv_fault_mask_i & `FCOA_MASK_WR_BITS;
            pw_set_q   <= nv_pw_set_i;
            loaded_q   <= 1'b1;
        end
        else if (wr_priv)
        begin
            // one byte per write
            if (sel_thr)
                los_thr_q <= wdata_i;
            if (sel_tmr)
                supp_tmr_q <= wdata_i;
            if (sel_msk)
                mask_q <= wdata_i & `FCOA_MASK_WR_BITS; // reserved bits dropped
            if (sel_pw)
                pw_set_q[addr_i[1:0]*8 +: 8] <= wdata_i;
        end
    end

    // password in effect latched only once after reset
    // typo cannot lock out
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            pw_live_q <= `FCOA_RST_PW;
        else if (!loaded_q)
            pw_live_q <= nv_pw_set_i;
    end

    // entered password field on the user page
    // reset relocks
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            pw_ent_q <= `FCOA_RST_PW;
        else if (wr_ent)
            pw_ent_q[pw_lane*8 +: 8] <= wdata_i;
    end

    // store write-through so contents survive power loss
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            nv_wr_q    <= 1'b0;
            nv_addr_q  <= `FCOA_RST_BYTE;
            nv_wdata_q <= `FCOA_RST_BYTE;
        end
        else
        begin
            nv_wr_q    <= wr_priv & loaded_q & (sel_thr | sel_tmr | sel_msk | sel_pw);
            nv_addr_q  <= addr_i;
            nv_wdata_q <= sel_msk ? (wdata_i & `FCOA_MASK_WR_BITS) : wdata_i;
        end
    end

    // read port; locked reads return zero with valid
    // bus engine never waits
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            rdata_q  <= `FCOA_RST_BYTE;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= rd_en_i;
            rdata_q  <= rd_priv ? rd_mux : `FCOA_RST_BYTE;
        end
    end

    // status outputs
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            fault_q <= 1'b0;
            // idles high
            int_n_q <= 1'b1;
            hour_q  <= 1'b0;
            unl_q   <= 1'b0;
        end
        else
        begin
            // unmasked only
            fault_q <= |fout_w;
            int_n_q <= ~(irq_src_i & global_interrupt_enable_i
                         & ~mask_q[`FCOA_BIT_PRIV_IRQ_MASK]);
            hour_q  <= mask_q[`FCOA_BIT_HOUR_EN];
            unl_q   <= unlocked & loaded_q;
        end
    end

    // port drivers
    assign rdata_o             = rdata_q;
    assign rvalid_o            = rvalid_q;
    assign nv_wr_o             = nv_wr_q;
    assign nv_addr_o           = nv_addr_q;
    assign nv_wdata_o          = nv_wdata_q;
    assign flags_o             = flag_w;
    assign fault_o             = fault_q;
    assign int_n_o             = int_n_q;
    assign hour_meter_enable_o = hour_q;
    assign priv_unlocked_o     = unl_q;
endmodule

// ===== fcoa_fault_props.sv
`timescale 1ns/1ps

// port-level checks for the fault configuration block
module fcoa_fault_props
    import fcoa_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    input  wire logic       wr_en_i,
    input  wire logic       rd_en_i,
    input  wire logic       priv_page_i,
    input  wire fcoa_byte_t addr_i,
    input  wire fcoa_byte_t wdata_i,
    input  wire fcoa_byte_t rdata_o,
    input  wire logic       rvalid_o,
    input  wire logic       nv_wr_o,
    input  wire fcoa_byte_t nv_addr_o,
    input  wire fcoa_byte_t nv_wdata_o,
    input  wire logic       fault_comparator_disable_i,
    input  wire logic       tx_high_i,
    input  wire logic       global_interrupt_enable_i,
    input  wire logic       irq_src_i,
    input  wire logic [4:0] flag_clr_i,
    input  wire logic [4:0] flags_o,
    input  wire logic       fault_o,
    input  wire logic       int_n_o,
    input  wire logic       hour_meter_enable_o,
    input  wire logic       priv_unlocked_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    // privileged accesses, locked and open
    sequence s_locked;
        priv_page_i && !priv_unlocked_o;
    endsequence
    sequence s_open_wr(a);
        wr_en_i && priv_page_i && priv_unlocked_o && addr_i == a;
    endsequence

    property p_locked_read;
        rd_en_i ##0 s_locked |=> rvalid_o && rdata_o == 8'h00;
    endproperty
    property p_locked_write;
        wr_en_i ##0 s_locked |=> !nv_wr_o;
    endproperty
    // store copy must carry the value written
    property p_store_update;
        fcoa_byte_t d;
        (s_open_wr(8'h09), d = wdata_i) |=> nv_wr_o && nv_addr_o == 8'h09 && nv_wdata_o == d;
    endproperty
    property p_irq_gate;
        !global_interrupt_enable_i || !irq_src_i |=> int_n_o;
    endproperty
    // comparator stopped means no new loss or tx flag
    property p_los_rise;
        $rose(flags_o[4]) |-> $past(!fault_comparator_disable_i);
    endproperty
    property p_tx_rise;
        $rose(flags_o[2]) |-> $past(tx_high_i && !fault_comparator_disable_i);
    endproperty
    property p_sticky;
        flags_o[0] && !flag_clr_i[0] |=> flags_o[0];
    endproperty
    property p_fault_clear;
        flags_o == 5'h00 |=> !fault_o;
    endproperty
    // hour meter follows mask bit 6 within two edges
    property p_hour;
        logic h;
        (s_open_wr(8'h0b), h = wdata_i[6]) |-> ##2 hour_meter_enable_o == h;
    endproperty

    a_locked_read: assert property (p_locked_read) else $error("locked read not zero");
    a_locked_write: assert property (p_locked_write) else $error("locked write kept");
    a_store_update: assert property (p_store_update) else $error("store update wrong");
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");
    a_los_rise: assert property (p_los_rise) else $error("loss flag while stopped");
    a_tx_rise: assert property (p_tx_rise) else $error("tx flag without cause");
    a_sticky: assert property (p_sticky) else $error("flag lost uncleared");
    a_fault_clear: assert property (p_fault_clear) else $error("fault without flag");
    a_hour: assert property (p_hour) else $error("hour meter enable wrong");
endmodule

bind fcoa_fault_config fcoa_fault_props i_fcoa_fault_props (
    .clock_i(clock_i), .reset_i(reset_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .priv_page_i(priv_page_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .nv_wr_o(nv_wr_o), .nv_addr_o(nv_addr_o), .nv_wdata_o(nv_wdata_o),
    .fault_comparator_disable_i(fault_comparator_disable_i), .tx_high_i(tx_high_i),
    .global_interrupt_enable_i(global_interrupt_enable_i), .irq_src_i(irq_src_i),
    .flag_clr_i(flag_clr_i), .flags_o(flags_o), .fault_o(fault_o), .int_n_o(int_n_o),
    .hour_meter_enable_o(hour_meter_enable_o), .priv_unlocked_o(priv_unlocked_o));

// ===== fcoa_host_model.sv
`timescale 1ns/1ps
`include "fcoa_regs.svh"

// serial bus host as seen at the register port
module fcoa_host_model
    import fcoa_pkg::*;
(
    input  wire logic       clock_i,
    input  wire fcoa_byte_t rdata_i,
    input  wire logic       rvalid_i,
    output logic            wr_en_o,
    output logic            rd_en_o,
    output logic            priv_page_o,
    output fcoa_byte_t      addr_o,
    output fcoa_byte_t      wdata_o
);
    initial
    begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        priv_page_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end

    // one write; released lines show inverted values, not stale ones
    task automatic wr(input logic p, input fcoa_byte_t a, input fcoa_byte_t d);
        @(posedge clock_i);
        #1;
        wr_en_o = 1'b1;
        priv_page_o = p;
        addr_o = a;
        wdata_o = (p && a == `FCOA_OFS_FAULT_MASK) ? (d & `FCOA_MASK_WR_BITS) : d;
        @(posedge clock_i);
        #1;
        wr_en_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~wdata_o;
    endtask

    // one read; answer taken one edge after the strobe
    task automatic rd(input logic p, input fcoa_byte_t a, output fcoa_byte_t d, output logic v);
        @(posedge clock_i);
        #1;
        rd_en_o = 1'b1;
        priv_page_o = p;
        addr_o = a;
        @(posedge clock_i);
        #1;
        rd_en_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
        v = rvalid_i;
    endtask

    // password entered on the user page, low byte first
    task automatic unlock(input logic [31:0] pw);
        for (int i = 0; i < 4; i++)
            wr(1'b0, `FCOA_OFS_PW_ENT0 + 8'(i), pw[8*i +: 8]);
    endtask
endmodule

// ===== fcoa_fault_config_test.sv
`timescale 1ns/1ps
`include "fcoa_regs.svh"
`define CHK(nm, ex, gt) \
begin \
    compares++; \
    if ((gt) !== (ex)) \
    begin \
        fails++; \
        $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); \
    end \
end

module fcoa_fault_config_test
    import fcoa_pkg::*;
;
    localparam logic [31:0] PW = 32'h1f2e3d4c;      // arbitrary password
    logic        clock_i, reset_i, wr_en_i, rd_en_i, priv_page_i, rvalid_o, nv_wr_o;
    fcoa_byte_t  addr_i, wdata_i, rdata_o, nv_addr_o, nv_wdata_o, rx, a, d;
    fcoa_byte_t  nv_thr, nv_tmr, nv_msk, seed = 8'h0e;
    logic [31:0] nv_pw, exp_pw;
    logic [4:0]  clr, flags_o;
    logic [3:0]  det;                               // sat, tx, bias, diode
    logic        dis, laser, ie, irq, fault_o, int_n_o, hour_o, unl_o;
    int          fails = 0, compares = 0, cycles = 0;

    fcoa_fault_config i_fcoa_fault_config (
        .clock_i(clock_i), .reset_i(reset_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
        .priv_page_i(priv_page_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .nv_los_thr_i(nv_thr), .nv_supp_tmr_i(nv_tmr),
        .nv_fault_mask_i(nv_msk), .nv_pw_set_i(nv_pw), .nv_wr_o(nv_wr_o),
        .nv_addr_o(nv_addr_o), .nv_wdata_o(nv_wdata_o), .fault_comparator_disable_i(dis),
        .rx_power_i(rx), .laser_on_i(laser), .sat_detect_i(det[3]), .tx_high_i(det[2]),
        .bias_high_i(det[1]), .diode_fault_i(det[0]), .global_interrupt_enable_i(ie),
        .irq_src_i(irq), .flag_clr_i(clr), .flags_o(flags_o), .fault_o(fault_o),
        .int_n_o(int_n_o), .hour_meter_enable_o(hour_o), .priv_unlocked_o(unl_o));
    fcoa_host_model i_fcoa_host_model (
        .clock_i(clock_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o), .wr_en_o(wr_en_i),
        .rd_en_o(rd_en_i), .priv_page_o(priv_page_i), .addr_o(addr_i), .wdata_o(wdata_i));

    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // store image follows every update pulse, as the backing memory would
    always @(posedge clock_i)
        if (nv_wr_o)
            case (nv_addr_o)
                8'h09:   nv_thr <= nv_wdata_o;
                8'h0a:   nv_tmr <= nv_wdata_o;
                8'h0b:   nv_msk <= nv_wdata_o;
                default: nv_pw[nv_addr_o[1:0]*8 +: 8] <= nv_wdata_o;
            endcase

    // hang guard, sized above the half-ms window plus the rest
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            fails++;
            final_report();
        end
    end

    function automatic fcoa_byte_t next_rand();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction

    // reserved mask bits read as zero
    function automatic fcoa_byte_t exp_rd(fcoa_byte_t ad, fcoa_byte_t dd);
        return (ad == 8'h0b) ? (dd & 8'hcf) : dd;
    endfunction

    task automatic tick(int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic do_reset();
        reset_i = 1'b1;
        tick(2);
        reset_i = 1'b0;
        tick(1);
    endtask

    task automatic check_rd(input fcoa_byte_t ad, input fcoa_byte_t e);
        fcoa_byte_t rv;
        logic v;
        i_fcoa_host_model.rd(1'b1, ad, rv, v);
        `CHK("rvalid", 1'b1, v)
        `CHK("rdata", e, rv)
    endtask

    task automatic final_report();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        {dis, laser, ie, irq, det, clr, rx} = {4'h0, 4'h0, 5'h00, 8'hff};
        {nv_thr, nv_tmr, nv_msk, nv_pw} = {8'h40, 16'h0000, PW};
        exp_pw = PW;
        do_reset();
        `CHK("int_n", 1'b1, int_n_o)
        check_rd(8'h09, 8'h00);
        i_fcoa_host_model.wr(1'b1, 8'h09, 8'h11);
        i_fcoa_host_model.unlock(PW ^ 32'h01000000);
        tick(2);
        `CHK("unlocked", 1'b0, unl_o)
        i_fcoa_host_model.unlock(PW);
        tick(2);
        `CHK("unlocked", 1'b1, unl_o)
        check_rd(8'h09, 8'h40);
        // random contents on every register, password bytes included
        for (int i = 0; i < 7; i++)
        begin
            a = 8'h09 + 8'(i);
            d = next_rand();
            i_fcoa_host_model.wr(1'b1, a, d);
            check_rd(a, exp_rd(a, d));
            if (a >= 8'h0c)
                exp_pw[a[1:0]*8 +: 8] = d;
        end
        `CHK("unlocked", 1'b1, unl_o)
        // each mask bit hides its channel yet the flag is kept
        i_fcoa_host_model.wr(1'b1, 8'h0a, 8'h00);
        laser = 1'b1;
        for (int b = 0; b < 4; b++)
            for (int m = 0; m < 2; m++)
            begin
                i_fcoa_host_model.wr(1'b1, 8'h0b, m ? (8'h01 << b) : 8'h00);
                det = 4'h1 << b;
                tick(3);
                det = 4'h0;
                tick(2);
                `CHK("flag", 1'b1, flags_o[b])
                `CHK("fault", (m == 0), fault_o)
                clr = 5'h01 << b;
                tick(1);
                clr = 5'h00;
            end
        // loss of signal strictly below the threshold
        i_fcoa_host_model.wr(1'b1, 8'h09, 8'h40);
        rx = 8'h40;
        tick(4);
        `CHK("los", 1'b0, flags_o[4])
        rx = 8'h3f;
        tick(4);
        `CHK("los", 1'b1, flags_o[4])
        dis = 1'b1;
        tick(3);
        `CHK("los", 1'b1, flags_o[4])
        clr = 5'h10;
        tick(1);
        clr = 5'h00;
        det = 4'h4;
        tick(4);
        `CHK("los tx", 2'b00, {flags_o[4], flags_o[2]})
        {dis, det, rx} = {1'b0, 4'h0, 8'hff};
        // interrupt gate and hour meter over all enable and mask pairs
        irq = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            ie = k[0];
            i_fcoa_host_model.wr(1'b1, 8'h0b, {k[1], k[0], 6'h00});
            tick(3);
            `CHK("int_n", !(k[0] && !k[1]), int_n_o)
            `CHK("hour", k[0], hour_o)
        end
        // one half-ms step of saturation suppression, then none
        for (int n = 1; n >= 0; n--)
        begin
            i_fcoa_host_model.wr(1'b1, 8'h0a, 8'(n));
            {laser, clr} = {1'b0, 5'h08};
            tick(2);
            {laser, clr, det} = {1'b1, 5'h00, 4'h8};
            if (n == 1)
            begin
                tick(`FCOA_TICK_CYCLES - 10);
                `CHK("sat early", 1'b0, flags_o[3])
                tick(20);
            end
            else
                tick(3);
            `CHK("sat", 1'b1, flags_o[3])
            det = 4'h0;
        end
        // new password acts only after reset; contents survive it
        do_reset();
        i_fcoa_host_model.unlock(exp_pw);
        tick(2);
        `CHK("unlocked", 1'b1, unl_o)
        check_rd(8'h09, 8'h40);
        final_report();
    end
endmodule
